// ==== src/bridge_config_header_regs.sv ====
// configuration words 0x30, 0x34 and 0x3c of a bridge header and their side effects
// assumes single-cycle config accesses on the primary clock; io base/limit bits 15:12 are
// supplied by the adjacent register bank, command register bits come in as inputs
`timescale 1ns/10ps
module bridge_config_header_regs
  import bridge_cfg_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // configuration access
  input wire logic cfg_read,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_offset,
  input wire logic [3:0] primary_byte_enable_lines,
  input wire logic [31:0] cfg_write_data,
  output logic [31:0] cfg_read_data,
  output logic cfg_hit,
  // io window bits 15:12 from the base/limit byte registers
  input wire logic [3:0] io_base_low_nibble,
  input wire logic [3:0] io_limit_low_nibble,
  // io addresses to decode
  input wire logic [31:0] primary_io_addr,
  input wire logic [31:0] secondary_io_addr,
  output logic forward_downstream,
  output logic forward_upstream,
  // error events from the secondary interface, one-cycle pulses, then the serr driver enable and reported clear
  input wire logic secondary_data_parity_error,
  input wire logic secondary_addr_parity_error,
  input wire logic secondary_system_error_pin_n,
  input wire logic primary_serr_driver_enable,
  input wire logic clear_data_parity_reported,
  // error pins, open drain, then the sticky data parity reported flag
  output logic secondary_parity_error_pin_o,
  output logic secondary_parity_error_pin_oe,
  output logic primary_system_error_pin_o,
  output logic primary_system_error_pin_oe,
  output logic data_parity_reported
);
  logic [15:0] io_base_upper_reg;
  logic [15:0] io_limit_upper_reg;
  logic [7:0] int_route_reg;
  logic parity_resp_reg;
  logic serr_fwd_reg;
  logic legacy_filt_reg;
  logic sperr_drive_reg;
  logic pserr_drive_reg;
  logic dpr_reg;
  logic sel_io;
  logic sel_cap;
  logic sel_ctrl;
  logic pserr_next;
  io_window_if win ();

  assign sel_io = (cfg_offset == OFS_IO_UPPER);
  assign sel_cap = (cfg_offset == OFS_CAP_PTR);
  assign sel_ctrl = (cfg_offset == OFS_INT_CTRL);
  assign cfg_hit = sel_io || sel_cap || sel_ctrl;

  // byte enables are active low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_base_upper_reg <= IO_UPPER_RESET;
      io_limit_upper_reg <= IO_UPPER_RESET;
    end else if (cfg_write && sel_io) begin
      if (!primary_byte_enable_lines[0]) io_base_upper_reg[7:0] <= cfg_write_data[7:0];
      if (!primary_byte_enable_lines[1]) io_base_upper_reg[15:8] <= cfg_write_data[15:8];
      if (!primary_byte_enable_lines[2]) io_limit_upper_reg[7:0] <= cfg_write_data[23:16];
      if (!primary_byte_enable_lines[3]) io_limit_upper_reg[15:8] <= cfg_write_data[31:24];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_route_reg <= INT_ROUTE_RESET;
      parity_resp_reg <= BRIDGE_CTRL_RESET[0];
      serr_fwd_reg <= BRIDGE_CTRL_RESET[1];
      legacy_filt_reg <= BRIDGE_CTRL_RESET[2];
    end else if (cfg_write && sel_ctrl) begin
      if (!primary_byte_enable_lines[0]) int_route_reg <= cfg_write_data[7:0];
      if (!primary_byte_enable_lines[2]) begin
        parity_resp_reg <= cfg_write_data[BIT_PARITY_RESP];
        serr_fwd_reg <= cfg_write_data[BIT_SERR_FWD];
        legacy_filt_reg <= cfg_write_data[BIT_LEGACY_FILT];
      end
    end
  end

  // read mux; the pointer word and pin byte are constants, so writes there vanish
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_read_data <= 32'h0000_0000;
    end else if (cfg_read) begin
      cfg_read_data <= 32'h0000_0000;
      if (sel_io) begin
        cfg_read_data <= {io_limit_upper_reg, io_base_upper_reg};
      end else if (sel_cap) begin
        cfg_read_data <= {24'h000000, CAP_PTR_VALUE};
      end else if (sel_ctrl) begin
        cfg_read_data <= {13'h0000, legacy_filt_reg, serr_fwd_reg, parity_resp_reg,
          INT_PIN_VALUE, int_route_reg};
      end
    end
  end

  // window bounds: low 12 bits implied, zeros below base, ones below limit
  assign win.base = {io_base_upper_reg, io_base_low_nibble, {IO_GRAN_BITS{1'b0}}};
  assign win.limit = {io_limit_upper_reg, io_limit_low_nibble, {IO_GRAN_BITS{1'b1}}};
  assign win.legacy_filter = legacy_filt_reg;
  assign win.primary_addr = primary_io_addr;
  assign win.secondary_addr = secondary_io_addr;
  assign forward_downstream = win.forward_down;
  assign forward_upstream = win.forward_up;

  io_window_decode u_decode (
    .win(win)
  );

  // parity pin is driven for one cycle after a data parity error
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sperr_drive_reg <= 1'b0;
    end else begin
      sperr_drive_reg <= secondary_data_parity_error && parity_resp_reg;
    end
  end

  // sticky reported bit; a new error beats a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dpr_reg <= 1'b0;
    end else if (secondary_data_parity_error && parity_resp_reg) begin
      dpr_reg <= 1'b1;
    end else if (clear_data_parity_reported) begin
      dpr_reg <= 1'b0;
    end
  end

  // the primary driver enable gates both sources, as the primary pin owner requires
  assign pserr_next = primary_serr_driver_enable &&
    ((secondary_addr_parity_error && parity_resp_reg) ||
     (!secondary_system_error_pin_n && serr_fwd_reg));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pserr_drive_reg <= 1'b0;
    end else begin
      pserr_drive_reg <= pserr_next;
    end
  end

  assign secondary_parity_error_pin_o = 1'b0;
  assign secondary_parity_error_pin_oe = sperr_drive_reg;
  assign primary_system_error_pin_o = 1'b0;
  assign primary_system_error_pin_oe = pserr_drive_reg;
  assign data_parity_reported = dpr_reg;

  cap_ptr_const_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_read && sel_cap |=> cfg_read_data == 32'h0000_0080)
    else $error("capability word wrong");
  int_pin_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_read && sel_ctrl |=> cfg_read_data[15:8] == 8'h00)
    else $error("interrupt pin byte not zero");
  limit_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    cfg_write && sel_io && primary_byte_enable_lines == 4'h0 |=>
    io_limit_upper_reg == $past(cfg_write_data[31:16]))
    else $error("limit half not written");
  sperr_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    !parity_resp_reg |=> !sperr_drive_reg)
    else $error("parity pin driven while disabled");
  sperr_drive_a: assert property (@(posedge clock) disable iff (!rst_n)
    secondary_data_parity_error && parity_resp_reg |=> sperr_drive_reg && dpr_reg)
    else $error("parity error not reported");
  addr_perr_a: assert property (@(posedge clock) disable iff (!rst_n)
    secondary_addr_parity_error && parity_resp_reg && primary_serr_driver_enable
    |=> primary_system_error_pin_oe)
    else $error("address parity not raised");
  serr_block_a: assert property (@(posedge clock) disable iff (!rst_n)
    !serr_fwd_reg && !secondary_addr_parity_error |=> !primary_system_error_pin_oe)
    else $error("system error forwarded while disabled");
  serr_fwd_a: assert property (@(posedge clock) disable iff (!rst_n)
    !secondary_system_error_pin_n && serr_fwd_reg && primary_serr_driver_enable
    |=> primary_system_error_pin_oe)
    else $error("system error not forwarded");
  filter_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    !legacy_filt_reg && primary_io_addr >= win.base && primary_io_addr <= win.limit
    |-> forward_downstream)
    else $error("window access not forwarded");
  filter_alias_a: assert property (@(posedge clock) disable iff (!rst_n)
    legacy_filt_reg && primary_io_addr[31:16] == 16'h0000 && primary_io_addr[9:8] != 2'h0
    |-> !forward_downstream)
    else $error("legacy alias forwarded");
endmodule

// ==== common/bridge_cfg_pkg.sv ====
// constants for the upper type-1 configuration header block
// assumes a 32-bit configuration data path with 4-bit active-low byte enables
package bridge_cfg_pkg;
  localparam logic [7:0] OFS_IO_UPPER = 8'h30;
  localparam logic [7:0] OFS_CAP_PTR = 8'h34;
  localparam logic [7:0] OFS_INT_CTRL = 8'h3c;
  localparam logic [15:0] IO_UPPER_RESET = 16'h0000;
  localparam logic [7:0] CAP_PTR_VALUE = 8'h80;
  localparam logic [7:0] INT_ROUTE_RESET = 8'hff;
  localparam logic [7:0] INT_PIN_VALUE = 8'h00;
  localparam logic [2:0] BRIDGE_CTRL_RESET = 3'h0;
  // bit positions within the word at 0x3c
  localparam int BIT_PARITY_RESP = 16;
  localparam int BIT_SERR_FWD = 17;
  localparam int BIT_LEGACY_FILT = 18;
  // io window granularity: 4KB, low 12 bits implied
  localparam int IO_GRAN_BITS = 12;
  // legacy filter: first 64KB, last 768 bytes of every 1KB block
  localparam int LEGACY_SPACE_BITS = 16;
  localparam logic [1:0] LEGACY_FIRST_QUARTER = 2'h0;
endpackage

// ==== common/io_window_if.sv ====
// carrier between the register bank and the io window decoder
// assumes one clock domain; all signals are combinational views
`timescale 1ns/10ps
interface io_window_if;
  logic [31:0] base;
  logic [31:0] limit;
  logic legacy_filter;
  logic [31:0] primary_addr;
  logic [31:0] secondary_addr;
  logic forward_down;
  logic forward_up;
  modport bank (output base, limit, legacy_filter, primary_addr, secondary_addr,
    input forward_down, forward_up);
  modport decoder (input base, limit, legacy_filter, primary_addr, secondary_addr,
    output forward_down, forward_up);
endinterface

// ==== src/io_window_decode.sv ====
// io window compare with optional legacy isa filtering
// assumes base and limit are already expanded to full 32-bit bounds
`timescale 1ns/10ps
module io_window_decode
  import bridge_cfg_pkg::*;
(
  io_window_if.decoder win
);
  logic down_in_window;
  logic up_in_window;
  logic down_legacy_alias;
  logic up_legacy_alias;

  // inclusive compare on both ends
  assign down_in_window = (win.primary_addr >= win.base) && (win.primary_addr <= win.limit);
  assign up_in_window = (win.secondary_addr >= win.base) &&
    (win.secondary_addr <= win.limit);

  // alias = first 64KB and address bits 9:8 not zero (last 768 of each 1KB)
  assign down_legacy_alias = (win.primary_addr[31:LEGACY_SPACE_BITS] == 16'h0000) &&
    (win.primary_addr[9:8] != LEGACY_FIRST_QUARTER);
  assign up_legacy_alias = (win.secondary_addr[31:LEGACY_SPACE_BITS] == 16'h0000) &&
    (win.secondary_addr[9:8] != LEGACY_FIRST_QUARTER);

  // filter off: whole window goes down filter on: aliases dropped
  assign win.forward_down = down_in_window && !(win.legacy_filter && down_legacy_alias);
  // aliases inside the filtered range come back upstream
  assign win.forward_up = win.legacy_filter && up_in_window && up_legacy_alias;
endmodule

// ==== dv/secondary_agent.sv ====
// secondary bus error source: parity and system error events
// assumes the primary clock; events launch just after a rising edge
`timescale 1ns/10ps
module secondary_agent (
  // clock
  input wire logic clock,
  // error events
  output logic data_parity_error,
  output logic addr_parity_error,
  output logic system_error_pin_n
);
  // the system error line idles high through its pull-up
  initial begin
    data_parity_error = 1'b0;
    addr_parity_error = 1'b0;
    system_error_pin_n = 1'b1;
  end
  // kind 0 data parity, 1 address parity, 2 system error; one cycle each
  task automatic raise(input int kind);
    @(posedge clock);
    data_parity_error <= (kind == 0);
    addr_parity_error <= (kind == 1);
    system_error_pin_n <= (kind != 2);
    @(posedge clock);
    data_parity_error <= 1'b0;
    addr_parity_error <= 1'b0;
    system_error_pin_n <= 1'b1;
  endtask
endmodule

// ==== dv/test_bridge_config_header_regs.sv ====
// self-checking bench for the upper configuration header block
// assumes fixed one-cycle read latency and registered error pin enables
`timescale 1ns/10ps
module test_bridge_config_header_regs import bridge_cfg_pkg::*;;
  logic clock = 1'b0, rst_n, cfg_read, cfg_write;
  logic [7:0] cfg_offset;
  logic [3:0] primary_byte_enable_lines, base_nib, lim_nib;
  logic [31:0] cfg_write_data, cfg_read_data, paddr, saddr;
  logic cfg_hit, down, up, dpe, ape, serr_n, drv_en, clr_rep;
  logic sp_o, sp_oe, pp_o, pp_oe, reported;
  int bad_count = 0, checks = 0;
  // both error lines are open drain with pull-ups
  wire s_perr_wire = sp_oe ? sp_o : 1'b1;
  wire p_serr_wire = pp_oe ? pp_o : 1'b1;
  always #5 clock = ~clock;
  secondary_agent agent_u (.clock(clock), .data_parity_error(dpe),
    .addr_parity_error(ape), .system_error_pin_n(serr_n));
  bridge_config_header_regs dut_u (.clock(clock), .rst_n(rst_n), .cfg_read(cfg_read),
    .cfg_write(cfg_write), .cfg_offset(cfg_offset),
    .primary_byte_enable_lines(primary_byte_enable_lines), .cfg_write_data(cfg_write_data),
    .cfg_read_data(cfg_read_data), .cfg_hit(cfg_hit), .io_base_low_nibble(base_nib),
    .io_limit_low_nibble(lim_nib), .primary_io_addr(paddr), .secondary_io_addr(saddr),
    .forward_downstream(down), .forward_upstream(up), .secondary_data_parity_error(dpe),
    .secondary_addr_parity_error(ape), .secondary_system_error_pin_n(serr_n),
    .primary_serr_driver_enable(drv_en), .clear_data_parity_reported(clr_rep),
    .secondary_parity_error_pin_o(sp_o), .secondary_parity_error_pin_oe(sp_oe),
    .primary_system_error_pin_o(pp_o), .primary_system_error_pin_oe(pp_oe),
    .data_parity_reported(reported));
  task automatic wrap_up();
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // byte enables are active low
  task automatic wr(input logic [7:0] off, input logic [3:0] be, input logic [31:0] d);
    @(posedge clock);
    cfg_write <= 1'b1;
    cfg_offset <= off;
    primary_byte_enable_lines <= be;
    cfg_write_data <= d;
    @(posedge clock);
    cfg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] off, input logic [31:0] exp);
    @(posedge clock);
    cfg_read <= 1'b1;
    cfg_offset <= off;
    @(posedge clock);
    cfg_read <= 1'b0;
    #1;
    chk(cfg_read_data, exp);
    chk_bit(cfg_hit, off == 8'h30 || off == 8'h34 || off == 8'h3c);
  endtask
  task automatic dec(input logic up_side, input logic [31:0] a, input logic exp);
    @(posedge clock);
    if (up_side) begin
      saddr <= a;
    end else begin
      paddr <= a;
    end
    #1;
    chk_bit(up_side ? up : down, exp);
  endtask
  task automatic t_regs();
    rd(8'h30, 32'h0);
    rd(8'h34, 32'h0000_0080);
    rd(8'h3c, 32'h0000_00ff);
    wr(8'h30, 4'h0, 32'h1234_abcd);
    wr(8'h30, 4'hc, 32'h5555_6666);
    rd(8'h30, 32'h1234_6666);
    wr(8'h30, 4'h3, 32'h7777_8888);
    rd(8'h30, 32'h7777_6666);
    wr(8'h34, 4'h0, 32'hffff_ffff);
    rd(8'h34, 32'h0000_0080);
    wr(8'h3c, 4'h0, 32'h0007_ff5a);
    rd(8'h3c, 32'h0007_005a);
    wr(8'h38, 4'h0, 32'hffff_ffff);
    rd(8'h38, 32'h0);
  endtask
  // window halves are programmed before any decode is judged
  task automatic t_window();
    wr(8'h3c, 4'hb, 32'h0);
    wr(8'h30, 4'h0, 32'h0001_0001);
    base_nib <= 4'h2;
    lim_nib <= 4'h3;
    dec(1'b0, 32'h0001_1fff, 1'b0);
    dec(1'b0, 32'h0001_2000, 1'b1);
    dec(1'b0, 32'h0001_3fff, 1'b1);
    dec(1'b0, 32'h0001_4000, 1'b0);
    dec(1'b0, 32'h0000_2000, 1'b0);
  endtask
  task automatic t_legacy();
    wr(8'h30, 4'h0, 32'h0);
    base_nib <= 4'h0;
    lim_nib <= 4'hf;
    wr(8'h3c, 4'hb, 32'h0004_0000);
    dec(1'b0, 32'h0000_0100, 1'b0);
    dec(1'b0, 32'h0000_00ff, 1'b1);
    dec(1'b0, 32'h0000_fc00, 1'b1);
    dec(1'b0, 32'h0000_ffff, 1'b0);
    dec(1'b1, 32'h0000_0500, 1'b1);
    dec(1'b1, 32'h0000_04ff, 1'b0);
    wr(8'h30, 4'h0, 32'h0001_0001);
    dec(1'b0, 32'h0001_0100, 1'b1);
    wr(8'h3c, 4'hb, 32'h0);
    dec(1'b0, 32'h0001_0500, 1'b1);
  endtask
  task automatic t_errors();
    agent_u.raise(0);
    #1;
    chk_bit(s_perr_wire, 1'b1);
    chk_bit(reported, 1'b0);
    agent_u.raise(1);
    #1;
    chk_bit(p_serr_wire, 1'b1);
    agent_u.raise(2);
    #1;
    chk_bit(p_serr_wire, 1'b1);
    wr(8'h3c, 4'hb, 32'h0003_0000);
    agent_u.raise(0);
    #1;
    chk_bit(s_perr_wire, 1'b0);
    chk_bit(reported, 1'b1);
    @(posedge clock);
    clr_rep <= 1'b1;
    #1;
    chk_bit(s_perr_wire, 1'b1);
    @(posedge clock);
    clr_rep <= 1'b0;
    #1;
    chk_bit(reported, 1'b0);
    agent_u.raise(1);
    #1;
    chk_bit(p_serr_wire, 1'b0);
    agent_u.raise(2);
    #1;
    chk_bit(p_serr_wire, 1'b0);
    @(posedge clock);
    drv_en <= 1'b0;
    agent_u.raise(2);
    #1;
    chk_bit(p_serr_wire, 1'b1);
    // the driver enable also gates the address parity path
    agent_u.raise(1);
    #1;
    chk_bit(p_serr_wire, 1'b1);
  endtask
  // a hung scenario still reaches the verdict
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    wrap_up();
  end
  initial begin
    rst_n <= 1'b0;
    cfg_read <= 1'b0;
    cfg_write <= 1'b0;
    cfg_offset <= 8'h00;
    primary_byte_enable_lines <= 4'hf;
    base_nib <= 4'h0;
    lim_nib <= 4'h0;
    cfg_write_data <= 32'h0;
    paddr <= 32'h0;
    saddr <= 32'h0;
    drv_en <= 1'b1;
    clr_rep <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_window();
    t_legacy();
    t_errors();
    wrap_up();
  end
endmodule
